// >>> core/asreg_pkg.sv
// Constants and carrier types for the per-strand ancillary state register bank.
// Assumes one core clock at 250 MHz and a synchronous active-high reset.
// Summary of operation
// RL1: Nonprivileged alternate access with space id 0x00..0x7F raises privileged action.
// RL2: Privileged, not hyperprivileged, access with id 0x30..0x7F raises privileged action.
// RL3: Space id register accepts any value from any privilege level.
// RL4: Cycle counter holds up to 63 bits and advances every clock.
// RL5: Counter bit 63 is the lock on nonprivileged reads.
// RL6: Privileged privreg write to counter is illegal and leaves it unchanged.
// RL7: Locked counter read by user code raises privileged action, else succeeds.
// RL8: User privreg read or write of counter raises privileged opcode.
// RL9: Narrower counter still lasts ten years; unbuilt upper bits read zero.
// RL10: Current and next instruction addresses keep bits 1:0 at zero.
// RL11: Instruction address readable only; write to register 5 is illegal.
// RL12: Next address never explicit; addresses change by transfers or retry only.
// RL13: Float op faults unless fp_state bit 2 and state_fp_on both set.
// RL14: fp_state bit 1 sets on upper float register change; software clears.
// RL15: fp_state bit 0 sets on lower float register change; software clears.
// RL16: Dirty bits may be set pessimistically on any float issue.
// RL17: A faulted float op still sets its destination dirty bit.
// RL18: Unused performance control bits read zero; software writes back zeros.
// RL19: Performance control free in privileged mode; user access is privileged opcode.
// RL20: Bits 16:11 and 9:4 select upper and lower counter events.
// RL21: Bit 2 counts user events, bit 1 counts privileged events.
// RL22: Bit 0 set makes user counter access raise privileged action.
// RL23: Faulting access changes nothing; exception reported with the access result.
// RL24: Cycle counter wraps to zero silently.
package asreg_pkg;

    localparam int          DATA_W         = 64;
    localparam int          NUM_W          = 5;
    localparam int          CLK_PERIOD_NS  = 4;
    localparam longint      TEN_YEARS_S    = 64'h0000_0000_12CF_5AC0;
    localparam longint      NS_PER_S       = 64'h0000_0000_3B9A_CA00;
    localparam longint      TEN_YEAR_CYC   = TEN_YEARS_S
                                             * (NS_PER_S / CLK_PERIOD_NS);
    localparam int          MIN_CNT_BITS   = $clog2(TEN_YEAR_CYC + 1);
    localparam int          MAX_CNT_BITS   = 63;

    localparam logic [NUM_W-1:0] ASR_SPACE_ID  = 5'h03;
    localparam logic [NUM_W-1:0] ASR_CYCLE_CNT = 5'h04;
    localparam logic [NUM_W-1:0] ASR_INSTR_ADR = 5'h05;
    localparam logic [NUM_W-1:0] ASR_FP_STATE  = 5'h06;
    localparam logic [NUM_W-1:0] ASR_PERF_CTL  = 5'h10;
    localparam logic [NUM_W-1:0] PREG_CYCLE    = 5'h04;

    localparam logic [7:0]  ASI_PRIV_LO    = 8'h30;
    localparam logic [7:0]  ASI_RESTR_HI   = 8'h7F;
    localparam int          LOCK_BIT       = 63;
    localparam int          FP_ON_BIT      = 2;
    localparam int          FP_UP_BIT      = 1;
    localparam int          FP_LO_BIT      = 0;
    localparam logic [63:0] PERF_CTL_MASK  = 64'h0000_0000_0001_FBF7;
    localparam logic [7:0]  ASI_RESET      = 8'h00;
    localparam logic [2:0]  FP_STATE_RESET = 3'h0;
    localparam logic [63:0] PERF_RESET     = 64'h0000_0000_0000_0000;
    localparam logic        LOCK_RESET     = 1'b1;

    typedef enum logic [2:0] {
        ASREG_OP_RD_ANC  = 3'h1,
        ASREG_OP_WR_ANC  = 3'h2,
        ASREG_OP_RD_PRIV = 3'h3,
        ASREG_OP_WR_PRIV = 3'h4
    } asreg_op_t;

    typedef enum logic [2:0] {
        ASREG_EXC_NONE     = 3'h0,
        ASREG_EXC_PRIV_ACT = 3'h1,
        ASREG_EXC_PRIV_OPC = 3'h2,
        ASREG_EXC_ILLEGAL  = 3'h3
    } asreg_exc_t;

    typedef struct packed {
        logic              valid;
        asreg_op_t         op;
        logic [NUM_W-1:0]  num;
        logic [DATA_W-1:0] wdata;
    } asreg_req_t;

    typedef struct packed {
        logic              valid;
        asreg_exc_t        exc;
        logic [DATA_W-1:0] rdata;
    } asreg_resp_t;

    typedef struct packed {
        logic              valid;
        logic              retry;
        logic [DATA_W-1:0] target;
        logic [DATA_W-1:0] saved_addr;
        logic [DATA_W-1:0] saved_next;
    } asreg_flow_t;

    typedef struct packed {
        logic valid;
        logic dest_upper;
        logic dest_lower;
    } asreg_fp_t;

    typedef struct packed {
        logic [5:0] upper_event_select;
        logic [5:0] lower_event_select;
        logic       user_count_on;
        logic       system_count_on;
        logic       counter_access_lock;
    } asreg_perf_t;

endpackage

// >>> core/asreg_bank.sv
// Ancillary state register bank for one strand: access checks and state.
// Assumes the pipeline presents at most one explicit access per cycle and
// that all inputs are synchronous to clk.
`timescale 1ns/1ns
module asreg_bank
    import asreg_pkg::*;
#(
    parameter int          CNT_BITS = MAX_CNT_BITS,
    parameter logic [63:0] RESET_PC = 64'h0000_0000_0000_0000
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        state_privileged,
    input  wire logic        hyper_privileged,
    input  wire logic        state_fp_on,
    input  wire asreg_req_t  req,
    output asreg_resp_t      resp_q,
    input  wire logic        asi_chk_valid,
    input  wire logic        asi_chk_use_imm,
    input  wire logic [7:0]  asi_chk_imm,
    output logic             asi_fault_q,
    input  wire asreg_fp_t   fp_issue,
    output logic             fp_off_fault_q,
    input  wire asreg_flow_t flow,
    output logic [63:0]      instr_address_q,
    output logic [63:0]      next_instr_address_q,
    input  wire logic        pic_chk_valid,
    output logic             pic_fault_q,
    output asreg_perf_t      perf_q
);

    // Narrower counters must still last ten years at this clock
    if (CNT_BITS < MIN_CNT_BITS || CNT_BITS > MAX_CNT_BITS) begin : g_cnt
        $error("CNT_BITS out of range");
    end

    logic [7:0]          alt_space_id_q;
    logic [CNT_BITS-1:0] cnt_q;
    logic                lock_q;
    logic [2:0]          fp_state_q;
    logic [63:0]         perf_ctl_q;

    logic                user_mode;
    logic                priv_only;
    logic                fp_enabled;
    asreg_exc_t          exc_d;
    logic [63:0]         rdata_d;
    logic                wr_asi;
    logic                wr_fp;
    logic                wr_perf;
    logic                wr_cnt;
    logic [7:0]          eff_asi;
    logic                asi_fault_d;
    logic                set_upper;
    logic                set_lower;

    assign user_mode  = !state_privileged && !hyper_privileged;
    assign priv_only  = state_privileged && !hyper_privileged;
    assign fp_enabled = fp_state_q[FP_ON_BIT] && state_fp_on;

    // Access decode; every write strobe is gated by a clean outcome
    always_comb begin
        exc_d   = ASREG_EXC_NONE;
        rdata_d = 64'h0000_0000_0000_0000;
        wr_asi  = 1'b0;
        wr_fp   = 1'b0;
        wr_perf = 1'b0;
        wr_cnt  = 1'b0;
        case (req.op)
            ASREG_OP_RD_ANC: begin
                if (req.num == ASR_SPACE_ID) begin
                    rdata_d = {56'h0000_0000_0000_00, alt_space_id_q};
                end else if (req.num == ASR_CYCLE_CNT) begin
                    if (user_mode && lock_q) begin
                        exc_d = ASREG_EXC_PRIV_ACT; // RL7
                    end else begin
                        rdata_d = {lock_q, 63'(cnt_q)}; // RL5 RL9
                    end
                end else if (req.num == ASR_INSTR_ADR) begin
                    rdata_d = instr_address_q; // RL11
                end else if (req.num == ASR_FP_STATE) begin
                    rdata_d = {61'h0, fp_state_q};
                end else if (req.num == ASR_PERF_CTL) begin
                    if (user_mode) begin
                        exc_d = ASREG_EXC_PRIV_OPC; // RL19
                    end else begin
                        rdata_d = perf_ctl_q; // RL18
                    end
                end else begin
                    exc_d = ASREG_EXC_ILLEGAL;
                end
            end
            ASREG_OP_WR_ANC: begin
                if (req.num == ASR_SPACE_ID) begin
                    wr_asi = 1'b1; // RL3
                end else if (req.num == ASR_FP_STATE) begin
                    wr_fp = 1'b1;
                end else if (req.num == ASR_PERF_CTL) begin
                    if (user_mode) begin
                        exc_d = ASREG_EXC_PRIV_OPC; // RL19
                    end else begin
                        wr_perf = 1'b1;
                    end
                end else begin
                    // Register 5 lands here: never writable
                    exc_d = ASREG_EXC_ILLEGAL; // RL11 RL12
                end
            end
            ASREG_OP_RD_PRIV: begin
                if (user_mode) begin
                    exc_d = ASREG_EXC_PRIV_OPC; // RL8
                end else if (req.num == PREG_CYCLE) begin
                    rdata_d = {lock_q, 63'(cnt_q)};
                end else begin
                    exc_d = ASREG_EXC_ILLEGAL;
                end
            end
            ASREG_OP_WR_PRIV: begin
                if (user_mode) begin
                    exc_d = ASREG_EXC_PRIV_OPC; // RL8
                end else if (req.num == PREG_CYCLE && !priv_only) begin
                    wr_cnt = 1'b1;
                end else begin
                    exc_d = ASREG_EXC_ILLEGAL; // RL6
                end
            end
            default: begin
                exc_d = ASREG_EXC_ILLEGAL;
            end
        endcase
        if (!req.valid) begin
            exc_d   = ASREG_EXC_NONE;
            wr_asi  = 1'b0;
            wr_fp   = 1'b0;
            wr_perf = 1'b0;
            wr_cnt  = 1'b0;
        end
    end

    // Outcome and read data leave together, one edge after the request
    always_ff @(posedge clk) begin
        if (reset) begin
            resp_q <= '0;
        end else begin
            resp_q.valid <= req.valid;
            resp_q.exc   <= exc_d; // RL23
            resp_q.rdata <= rdata_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            alt_space_id_q <= ASI_RESET;
        end else if (wr_asi) begin
            alt_space_id_q <= req.wdata[7:0]; // RL3
        end
    end

    // Restriction is checked only when an access uses the identifier
    always_comb begin
        eff_asi     = asi_chk_use_imm ? asi_chk_imm : alt_space_id_q;
        asi_fault_d = 1'b0;
        if (asi_chk_valid && user_mode && eff_asi <= ASI_RESTR_HI) begin
            asi_fault_d = 1'b1; // RL1
        end
        if (asi_chk_valid && priv_only && eff_asi >= ASI_PRIV_LO
            && eff_asi <= ASI_RESTR_HI) begin
            asi_fault_d = 1'b1; // RL2
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            asi_fault_q <= 1'b0;
        end else begin
            asi_fault_q <= asi_fault_d;
        end
    end

    // Free-running; the wrap is silent by design
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q  <= '0;
            lock_q <= LOCK_RESET;
        end else if (wr_cnt) begin
            cnt_q  <= req.wdata[CNT_BITS-1:0];
            lock_q <= req.wdata[LOCK_BIT]; // RL5
        end else begin
            cnt_q  <= cnt_q + 1'b1; // RL4 RL24
        end
    end

    // Dirty marks are pessimistic: any issue naming a half sets it,
    // faulted or not, and a hardware set beats a software clear
    assign set_upper = fp_issue.valid && fp_issue.dest_upper; // RL16 RL17
    assign set_lower = fp_issue.valid && fp_issue.dest_lower; // RL16 RL17

    always_ff @(posedge clk) begin
        if (reset) begin
            fp_state_q <= FP_STATE_RESET;
        end else begin
            if (wr_fp) begin
                fp_state_q[FP_ON_BIT] <= req.wdata[FP_ON_BIT];
            end
            fp_state_q[FP_UP_BIT] <= set_upper ||
                (wr_fp ? req.wdata[FP_UP_BIT] : fp_state_q[FP_UP_BIT]); // RL14
            fp_state_q[FP_LO_BIT] <= set_lower ||
                (wr_fp ? req.wdata[FP_LO_BIT] : fp_state_q[FP_LO_BIT]); // RL15
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fp_off_fault_q <= 1'b0;
        end else begin
            fp_off_fault_q <= fp_issue.valid && !fp_enabled; // RL13
        end
    end

    // Bits 1:0 are forced clear whatever the source supplies
    always_ff @(posedge clk) begin
        if (reset) begin
            instr_address_q      <= {RESET_PC[63:2], 2'b00};
            next_instr_address_q <= {RESET_PC[63:2] + 62'h1, 2'b00};
        end else if (flow.retry) begin
            instr_address_q      <= {flow.saved_addr[63:2], 2'b00}; // RL12
            next_instr_address_q <= {flow.saved_next[63:2], 2'b00}; // RL10
        end else if (flow.valid) begin
            instr_address_q      <= next_instr_address_q; // RL12
            next_instr_address_q <= {flow.target[63:2], 2'b00}; // RL10
        end
    end

    // Unimplemented bits are never stored, so they read zero
    always_ff @(posedge clk) begin
        if (reset) begin
            perf_ctl_q <= PERF_RESET;
        end else if (wr_perf) begin
            perf_ctl_q <= req.wdata & PERF_CTL_MASK; // RL18
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            perf_q <= '0;
        end else begin
            perf_q.upper_event_select  <= perf_ctl_q[16:11]; // RL20
            perf_q.lower_event_select  <= perf_ctl_q[9:4]; // RL20
            perf_q.user_count_on       <= perf_ctl_q[2]; // RL21
            perf_q.system_count_on     <= perf_ctl_q[1]; // RL21
            perf_q.counter_access_lock <= perf_ctl_q[0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pic_fault_q <= 1'b0;
        end else begin
            pic_fault_q <= pic_chk_valid && user_mode
                           && perf_ctl_q[0]; // RL22
        end
    end

    chk_asi_user_fault: assert property ( // RL1
        @(posedge clk) disable iff (reset)
        asi_chk_valid && user_mode && eff_asi <= 8'h7F |=> asi_fault_q)
        else $error("user restricted space id not faulted");

    chk_asi_priv_band: assert property ( // RL2
        @(posedge clk) disable iff (reset)
        asi_chk_valid && priv_only |=>
        asi_fault_q == ($past(eff_asi) >= 8'h30 && $past(eff_asi) <= 8'h7F))
        else $error("privileged space id check wrong");

    chk_count_advance: assert property ( // RL4
        @(posedge clk) disable iff (reset)
        !reset && !wr_cnt |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("cycle counter did not advance");

    chk_count_wr_illegal: assert property ( // RL6
        @(posedge clk) disable iff (reset)
        req.valid && req.op == ASREG_OP_WR_PRIV && priv_only
        |=> resp_q.exc == ASREG_EXC_ILLEGAL && $stable(lock_q))
        else $error("privileged counter write not refused");

    chk_count_lock_read: assert property ( // RL7
        @(posedge clk) disable iff (reset)
        req.valid && req.op == ASREG_OP_RD_ANC && req.num == 5'h04
        && user_mode |=> resp_q.exc ==
        ($past(lock_q) ? ASREG_EXC_PRIV_ACT : ASREG_EXC_NONE))
        else $error("locked counter read outcome wrong");

    chk_preg_user: assert property ( // RL8
        @(posedge clk) disable iff (reset)
        req.valid && user_mode && (req.op == ASREG_OP_RD_PRIV
        || req.op == ASREG_OP_WR_PRIV) |=> resp_q.exc == ASREG_EXC_PRIV_OPC)
        else $error("user privreg access not faulted");

    chk_addr_align: assert property ( // RL10
        @(posedge clk) disable iff (reset)
        instr_address_q[1:0] == 2'b00 && next_instr_address_q[1:0] == 2'b00)
        else $error("instruction address misaligned");

    chk_addr_no_write: assert property ( // RL11
        @(posedge clk) disable iff (reset)
        req.valid && req.op == ASREG_OP_WR_ANC && req.num == 5'h05
        && !flow.valid && !flow.retry
        |=> resp_q.exc == ASREG_EXC_ILLEGAL && $stable(instr_address_q))
        else $error("instruction address write not refused");

    chk_fp_gate: assert property ( // RL13
        @(posedge clk) disable iff (reset)
        fp_issue.valid |=>
        fp_off_fault_q == !($past(fp_state_q[2]) && $past(state_fp_on)))
        else $error("float enable gating wrong");

    chk_dirty_wins: assert property ( // RL14 RL15 RL17
        @(posedge clk) disable iff (reset)
        fp_issue.valid && fp_issue.dest_upper && fp_issue.dest_lower
        |=> fp_state_q[1:0] == 2'b11)
        else $error("dirty mark lost");

    chk_perf_user: assert property ( // RL19
        @(posedge clk) disable iff (reset)
        req.valid && user_mode && req.num == 5'h10 && (req.op ==
        ASREG_OP_RD_ANC || req.op == ASREG_OP_WR_ANC)
        |=> resp_q.exc == ASREG_EXC_PRIV_OPC && $stable(perf_ctl_q))
        else $error("user performance control access not faulted");

    chk_pic_lock: assert property ( // RL22
        @(posedge clk) disable iff (reset)
        pic_chk_valid && user_mode && perf_ctl_q[0] |=> pic_fault_q)
        else $error("locked counter access not faulted");

endmodule

// >>> verification/asreg_pipe_model.sv
// Pipeline model: issues explicit register accesses to the bank.
// Assumes the bank answers on the same edge that takes a request.
`timescale 1ns/1ns
module asreg_pipe_model
    import asreg_pkg::*;
(
    input  wire logic        clk,
    output asreg_req_t       req,
    input  wire asreg_resp_t resp_q
);
    initial req = '0;

    // Software keeps unused control bits at zero on every write
    function automatic asreg_req_t tidy(input asreg_req_t r);
        asreg_req_t c;
        c = r;
        if (r.op == ASREG_OP_WR_ANC && r.num == ASR_PERF_CTL) begin
            c.wdata = r.wdata & PERF_CTL_MASK;
        end
        return c;
    endfunction

    // A valid second request follows the first with no idle cycle
    task automatic send(input  asreg_req_t  a,
                        input  asreg_req_t  b,
                        output asreg_resp_t ra,
                        output asreg_resp_t rb);
        @(posedge clk);
        req <= tidy(a);
        @(posedge clk);
        req <= tidy(b);
        #1 ra = resp_q;
        rb = '0;
        if (b.valid) begin
            @(posedge clk);
            req <= '0;
            #1 rb = resp_q;
        end
    endtask
endmodule

// >>> verification/asreg_bank_bench.sv
// Self-checking bench for the ancillary state register bank.
// Assumes the pipeline model drives the access port; all else from here.
`timescale 1ns/1ns
module asreg_bank_bench
    import asreg_pkg::*;
;
    typedef struct packed {
        logic       p;
        logic       h;
        logic [7:0] id;
        logic       f;
    } asreg_row_t;

    localparam logic [63:0] PC0 = 64'h0000_0000_0000_1003;

    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        state_privileged = 1'b0;
    logic        hyper_privileged = 1'b0;
    logic        state_fp_on = 1'b0;
    asreg_req_t  req;
    asreg_resp_t resp_q;
    logic        asi_chk_valid = 1'b0;
    logic        asi_chk_use_imm = 1'b0;
    logic [7:0]  asi_chk_imm = 8'h00;
    logic        asi_fault_q;
    asreg_fp_t   fp_issue = '0;
    logic        fp_off_fault_q;
    asreg_flow_t flow = '0;
    logic [63:0] instr_address_q;
    logic [63:0] next_instr_address_q;
    logic        pic_chk_valid = 1'b0;
    logic        pic_fault_q;
    asreg_perf_t perf_q;
    asreg_row_t  rows [10];
    logic [63:0] v;
    logic [63:0] a;
    logic [63:0] b;
    asreg_resp_t ra;
    asreg_resp_t rb;
    int          errors = 0;
    int          comparisons = 0;

    always #2 clk = ~clk;

    asreg_bank #(.RESET_PC(PC0)) i_asreg_bank (
        .clk                  (clk),
        .reset                (reset),
        .state_privileged     (state_privileged),
        .hyper_privileged     (hyper_privileged),
        .state_fp_on          (state_fp_on),
        .req                  (req),
        .resp_q               (resp_q),
        .asi_chk_valid        (asi_chk_valid),
        .asi_chk_use_imm      (asi_chk_use_imm),
        .asi_chk_imm          (asi_chk_imm),
        .asi_fault_q          (asi_fault_q),
        .fp_issue             (fp_issue),
        .fp_off_fault_q       (fp_off_fault_q),
        .flow                 (flow),
        .instr_address_q      (instr_address_q),
        .next_instr_address_q (next_instr_address_q),
        .pic_chk_valid        (pic_chk_valid),
        .pic_fault_q          (pic_fault_q),
        .perf_q               (perf_q)
    );

    asreg_pipe_model i_asreg_pipe_model (
        .clk    (clk),
        .req    (req),
        .resp_q (resp_q)
    );

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic done(input string name);
        $display("Test %s done", name);
    endtask

    task automatic mode(input logic p, input logic h, input logic f);
        @(posedge clk);
        state_privileged <= p;
        hyper_privileged <= h;
        state_fp_on <= f;
    endtask

    // Faulting answers must carry no read data
    task automatic acc(input asreg_op_t op, input logic [4:0] num,
                       input logic [63:0] wd, input asreg_exc_t exc,
                       output logic [63:0] rd);
        i_asreg_pipe_model.send({1'b1, op, num, wd}, '0, ra, rb);
        check("resp valid", ra.valid, 64'h1);
        check("resp exc", ra.exc, exc);
        if (exc != ASREG_EXC_NONE) check("resp rdata", ra.rdata, 0);
        rd = ra.rdata;
    endtask

    task automatic asi_try(input logic p, input logic h, input logic sel,
                           input logic [7:0] id, input logic exp);
        @(posedge clk);
        state_privileged <= p;
        hyper_privileged <= h;
        asi_chk_valid <= 1'b1;
        asi_chk_use_imm <= sel;
        asi_chk_imm <= id;
        @(posedge clk);
        asi_chk_valid <= 1'b0;
        #1 check("space id fault", asi_fault_q, exp);
    endtask

    task automatic fp_try(input logic up, input logic lo, input logic exp);
        @(posedge clk);
        fp_issue <= {1'b1, up, lo};
        @(posedge clk);
        fp_issue <= '0;
        #1 check("fp off fault", fp_off_fault_q, exp);
    endtask

    task automatic pic_try(input logic exp);
        @(posedge clk);
        pic_chk_valid <= 1'b1;
        @(posedge clk);
        pic_chk_valid <= 1'b0;
        #1 check("counter access fault", pic_fault_q, exp);
    endtask

    task automatic flow_go(input asreg_flow_t f, input logic [63:0] pc,
                           input logic [63:0] next_instr_address);
        @(posedge clk);
        flow <= f;
        @(posedge clk);
        flow <= '0;
        #1 check("instr address", instr_address_q, pc);
        check("next instr address", next_instr_address_q, next_instr_address);
    endtask

    // Watchdog: the sequence needs about 130 cycles
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        $display("Error watchdog expected finish seen timeout");
        report_and_stop();
    end

    initial begin
        rows = '{'{0, 0, 8'h00, 1}, '{0, 0, 8'h7F, 1}, '{0, 0, 8'h80, 0},
                 '{0, 0, 8'hFF, 0}, '{1, 0, 8'h2F, 0}, '{1, 0, 8'h30, 1},
                 '{1, 0, 8'h7F, 1}, '{1, 0, 8'h80, 0}, '{1, 1, 8'h30, 0},
                 '{1, 1, 8'h7F, 0}};
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1 check("reset pc", instr_address_q, PC0 & ~64'h3);
        check("reset npc", next_instr_address_q, 64'h1004);
        check("reset perf", perf_q, 0);
        done("reset");
        for (int i = 0; i < 10; i++) begin
            asi_try(rows[i].p, rows[i].h, 1'b1, rows[i].id, rows[i].f);
        end
        done("space id table");
        mode(0, 0, 0);
        acc(ASREG_OP_WR_ANC, ASR_SPACE_ID, 64'h55, ASREG_EXC_NONE, v);
        asi_try(0, 0, 0, 8'h00, 1);
        asi_try(1, 0, 0, 8'h00, 1);
        i_asreg_pipe_model.send({1'b1, ASREG_OP_WR_ANC, ASR_SPACE_ID,
                                 64'hA5}, {1'b1, ASREG_OP_RD_ANC,
                                 ASR_SPACE_ID, 64'h0}, ra, rb);
        check("space id back to back", rb.rdata, 64'hA5);
        asi_try(0, 0, 0, 8'h00, 0);
        done("space id register");
        mode(0, 0, 0);
        acc(ASREG_OP_RD_ANC, ASR_CYCLE_CNT, 0, ASREG_EXC_PRIV_ACT, v);
        acc(ASREG_OP_RD_PRIV, PREG_CYCLE, 0, ASREG_EXC_PRIV_OPC, v);
        acc(ASREG_OP_WR_PRIV, PREG_CYCLE, 0, ASREG_EXC_PRIV_OPC, v);
        mode(1, 0, 0);
        acc(ASREG_OP_RD_ANC, ASR_CYCLE_CNT, 0, ASREG_EXC_NONE, a);
        check("lock after reset", a[63], 1);
        acc(ASREG_OP_WR_PRIV, PREG_CYCLE, 0, ASREG_EXC_ILLEGAL, v);
        acc(ASREG_OP_WR_ANC, ASR_CYCLE_CNT, 0, ASREG_EXC_ILLEGAL, v);
        acc(ASREG_OP_RD_PRIV, PREG_CYCLE, 0, ASREG_EXC_NONE, b);
        check("counter advance", b, a + 64'h6);
        mode(1, 1, 0);
        acc(ASREG_OP_WR_PRIV, PREG_CYCLE, 64'h7FFF_FFFF_FFFF_FFFD,
            ASREG_EXC_NONE, v);
        acc(ASREG_OP_RD_ANC, ASR_CYCLE_CNT, 0, ASREG_EXC_NONE, a);
        acc(ASREG_OP_RD_ANC, ASR_CYCLE_CNT, 0, ASREG_EXC_NONE, b);
        check("wrap step", {1'b0, b[62:0] - a[62:0]}, 64'h2);
        check("wrap low", b[62:2], 0);
        check("lock cleared", b[63], 0);
        mode(0, 0, 0);
        acc(ASREG_OP_RD_ANC, ASR_CYCLE_CNT, 0, ASREG_EXC_NONE, v);
        done("cycle counter");
        mode(1, 0, 0);
        acc(ASREG_OP_RD_ANC, ASR_INSTR_ADR, 0, ASREG_EXC_NONE, v);
        check("read pc", v, 64'h1000);
        acc(ASREG_OP_WR_ANC, ASR_INSTR_ADR, 64'h40, ASREG_EXC_ILLEGAL, v);
        check("pc kept", instr_address_q, 64'h1000);
        flow_go({1'b1, 1'b0, 64'h2007, 64'h0, 64'h0}, 64'h1004, 64'h2004);
        flow_go({1'b1, 1'b1, 64'h5000, 64'h3001, 64'h4002}, 64'h3000,
                64'h4000);
        done("instr address");
        mode(0, 0, 0);
        acc(ASREG_OP_WR_ANC, ASR_FP_STATE, 0, ASREG_EXC_NONE, v);
        fp_try(1, 0, 1);
        acc(ASREG_OP_RD_ANC, ASR_FP_STATE, 0, ASREG_EXC_NONE, v);
        check("fp state upper", v, 64'h2);
        acc(ASREG_OP_WR_ANC, ASR_FP_STATE, 64'h4, ASREG_EXC_NONE, v);
        mode(0, 0, 1);
        fp_try(0, 1, 0);
        acc(ASREG_OP_RD_ANC, ASR_FP_STATE, 0, ASREG_EXC_NONE, v);
        check("fp state lower", v, 64'h5);
        mode(0, 0, 0);
        fp_try(0, 0, 1);
        fork
            fp_try(1, 1, 1);
            acc(ASREG_OP_WR_ANC, ASR_FP_STATE, 0, ASREG_EXC_NONE, v);
        join
        acc(ASREG_OP_RD_ANC, ASR_FP_STATE, 0, ASREG_EXC_NONE, v);
        check("dirty wins", v, 64'h3);
        done("fp state");
        mode(1, 0, 0);
        acc(ASREG_OP_WR_ANC, ASR_PERF_CTL, 64'hFFFF_FFFF_FFFF_FFFF,
            ASREG_EXC_NONE, v);
        acc(ASREG_OP_WR_ANC, ASR_PERF_CTL, 64'h0001_5A35, ASREG_EXC_NONE, v);
        acc(ASREG_OP_RD_ANC, ASR_PERF_CTL, 0, ASREG_EXC_NONE, v);
        check("perf ctl read", v, 64'h0001_5A35);
        check("perf fields", perf_q, {6'h2B, 6'h23, 3'h5});
        mode(0, 0, 0);
        pic_try(1);
        acc(ASREG_OP_RD_ANC, ASR_PERF_CTL, 0, ASREG_EXC_PRIV_OPC, v);
        acc(ASREG_OP_WR_ANC, ASR_PERF_CTL, 0, ASREG_EXC_PRIV_OPC, v);
        acc(ASREG_OP_RD_ANC, 5'h07, 0, ASREG_EXC_ILLEGAL, v);
        mode(1, 0, 0);
        pic_try(0);
        acc(ASREG_OP_RD_ANC, ASR_PERF_CTL, 0, ASREG_EXC_NONE, v);
        check("perf kept", v, 64'h0001_5A35);
        done("perf control");
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1 check("rereset pc", instr_address_q, 64'h1000);
        check("rereset perf", perf_q, 0);
        acc(ASREG_OP_RD_ANC, ASR_CYCLE_CNT, 0, ASREG_EXC_NONE, v);
        check("rereset lock", v[63], 1);
        done("second reset");
        report_and_stop();
    end
endmodule
